// [common/fmas_pkg.sv]
// shared constants, types and helpers for the four-lane multiply-add datapath
package fmas_pkg;
    localparam int FMAS_ADDR_W = 5;
    localparam logic [4:0] FMAS_CTRL_OFS = 5'h00;
    localparam logic [4:0] FMAS_PRELOAD_OFS = 5'h04;
    localparam logic [4:0] FMAS_CIDX_OFS = 5'h08;
    localparam logic [4:0] FMAS_CDATA_OFS = 5'h0c;
    localparam logic [4:0] FMAS_RES_LO_OFS = 5'h10;
    localparam logic [4:0] FMAS_RES_HI_OFS = 5'h14;
    localparam int FMAS_ACC_EN_BIT = 0;
    localparam int FMAS_ACC_SUB_BIT = 1;
    localparam int FMAS_LOAD_HIGH_BIT = 2;
    localparam int FMAS_AREP_LSB = 4;
    localparam logic [5:0] FMAS_CTRL_MASK = 6'h37;
    localparam logic [5:0] FMAS_CTRL_RST = 6'h00;
    // exponent 64 selects a zero preload constant
    localparam logic [6:0] FMAS_PRELOAD_RST = 7'h40;
    localparam logic [6:0] FMAS_PRELOAD_ZERO = 7'h40;
    localparam int FMAS_MAX_LANES = 4;
    localparam int FMAS_COEF_SEL_W = 3;
    localparam int FMAS_COEF_WORDS = 32;
    localparam int FMAS_SEL_NONE = 2;

    typedef enum logic [1:0] {FMAS_A_UNSIGNED, FMAS_A_SIGNED, FMAS_A_VARIABLE} fmas_arep_t;
    typedef enum logic [1:0] {FMAS_PRE_SIMPLE, FMAS_PRE_COEF, FMAS_PRE_INPUT,
                              FMAS_PRE_CONST} fmas_pre_t;

    // picks one of two control lines, or a fixed level when no source is assigned
    function automatic logic fmas_pick(input logic [1:0] v, input int sel, input logic dflt);
        if (sel >= FMAS_SEL_NONE)
            return dflt;
        return v[sel];
    endfunction

    function automatic logic [31:0] fmas_be_merge(input logic [31:0] old,
                                                  input logic [31:0] nw,
                                                  input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                m[i*8 +: 8] = nw[i*8 +: 8];
        end
        return m;
    endfunction
endpackage

// [design/fmas_stage.sv]
// one register bank with selectable clock enable, clears and enable
`timescale 1ns/100ps
module fmas_stage import fmas_pkg::*; #(
    parameter int W = 8,
    parameter bit USED = 1'b1,
    parameter int CLK_SEL = 0,
    parameter int ACLR_SEL = FMAS_SEL_NONE,
    parameter int SCLR_SEL = FMAS_SEL_NONE,
    parameter int ENA_SEL = FMAS_SEL_NONE
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [1:0] reg_clk_en,
    input wire logic [1:0] aclr,
    input wire logic [1:0] sclr,
    input wire logic [1:0] ena,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;
    logic arst_n;
    logic tick;
    logic clr;

    // the chosen clear joins the chip reset, so the flop only ever resets to zero
    assign arst_n = rstn & ~fmas_pick(aclr, ACLR_SEL, 1'b0); // RULE5
    assign tick = reg_clk_en[CLK_SEL];                       // RULE4
    assign clr = fmas_pick(sclr, SCLR_SEL, 1'b0);

    always_comb
    begin
        nxt_q = q_ff;
        // sync clear acts on the stage's own clock tick, whatever the enable does
        if (tick && clr)
            nxt_q = '0;                                      // RULE5
        else if (tick && fmas_pick(ena, ENA_SEL, 1'b1))
            nxt_q = d;                                       // RULE6
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            q_ff <= '0;
        else
            q_ff <= nxt_q;
    end

    assign q = USED ? q_ff : d;
endmodule

// [design/fmas_top.sv]
// four-lane multiply-add datapath with accumulator, cascade input and register port
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
// What this block does
// RULE1: one A operand bus per lane, lane count times A width wide.
// RULE2: one B operand bus per lane, lane count times B width wide.
// RULE3: C operand buses are used only when the pre-adder takes port input.
// RULE4: two clock inputs; every register bank picks one at build time.
// RULE5: two async and two sync clears; assigned banks clear now or next edge.
// RULE6: two enables; an assigned bank updates only while its enable is high.
// RULE7: variable A format: sign-A high means signed A, low means unsigned.
// RULE8: sign-B high means B is two's complement, low means unsigned.
// RULE9: active-low load mode: low loads the product path, high the preload constant.
// RULE10: active-high load mode: high loads the product path, low the preload constant.
// RULE11: user logic drives only one of the two load controls per configuration.
// RULE12: the cascade input from a previous stage is added into the sum.
// RULE13: first add/sub control: 1 adds lanes one and two, 0 subtracts.
// RULE14: second add/sub control: 1 adds lanes three and four, 0 subtracts.
// RULE15: in shift-chain mode lane zero takes A from the scan-in bus.
// RULE16: scan-out shows the last lane's A, only with over two lanes chained.
// RULE17: each lane has its own coefficient pick input.
// RULE18: one result bus of configurable width carries the combined sum.
// RULE19: preload constant is two to the power N; N of 64 gives zero.
// RULE20: each lane holds preset coefficients, reset to zero, used in coef modes.
// RULE21: enabled accumulator adds or subtracts per its configured operation.
// RULE22: result is pair sums plus cascade plus feedback; each bank adds a cycle.
module fmas_top import fmas_pkg::*; #(
    parameter int LANE_COUNT = 4,
    parameter int WA = 18,
    parameter int WB = 18,
    parameter int WC = 18,
    parameter int WK = 18,
    parameter int WCH = 44,
    parameter int WR = 64,
    parameter bit A_FROM_SHIFT_CHAIN = 1'b0,
    parameter fmas_pre_t PRE_MODE = FMAS_PRE_SIMPLE,
    parameter bit IN_USED = 1'b1,
    parameter int IN_CLK = 0,
    parameter int IN_ACLR = FMAS_SEL_NONE,
    parameter int IN_SCLR = FMAS_SEL_NONE,
    parameter int IN_ENA = FMAS_SEL_NONE,
    parameter bit PIPE_USED = 1'b1,
    parameter int PIPE_CLK = 0,
    parameter int PIPE_ACLR = FMAS_SEL_NONE,
    parameter int PIPE_SCLR = FMAS_SEL_NONE,
    parameter int PIPE_ENA = FMAS_SEL_NONE,
    parameter int OUT_CLK = 0,
    parameter int OUT_ACLR = FMAS_SEL_NONE,
    parameter int OUT_SCLR = FMAS_SEL_NONE,
    parameter int OUT_ENA = FMAS_SEL_NONE
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [1:0] reg_clk_en,
    input wire logic [1:0] aclr,
    input wire logic [1:0] sclr,
    input wire logic [1:0] ena,
    input wire logic [LANE_COUNT*WA-1:0] a_in,
    input wire logic [LANE_COUNT*WB-1:0] b_in,
    input wire logic [LANE_COUNT*WC-1:0] c_in,
    input wire logic sign_a,
    input wire logic sign_b,
    input wire logic [WA-1:0] scan_in,
    input wire logic accum_load_n,
    input wire logic load_accum,
    input wire logic [WCH-1:0] chain_in,
    input wire logic pair_one_add_sub,
    input wire logic pair_two_add_sub,
    input wire logic [FMAS_COEF_SEL_W-1:0] coeff_pick_lane0,
    input wire logic [FMAS_COEF_SEL_W-1:0] coeff_pick_lane1,
    input wire logic [FMAS_COEF_SEL_W-1:0] coeff_pick_lane2,
    input wire logic [FMAS_COEF_SEL_W-1:0] coeff_pick_lane3,
    output logic [WR-1:0] result,
    output logic [WA-1:0] scan_out,
    input wire logic [FMAS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    localparam int CSW = FMAS_COEF_SEL_W;
    localparam int BO = LANE_COUNT*WA;
    localparam int CO = BO + LANE_COUNT*WB;
    localparam int KO = CO + LANE_COUNT*WC;
    localparam int FO = KO + FMAS_MAX_LANES*CSW;
    localparam int HO = FO + 6;
    localparam int IW = HO + WCH;
    localparam int PW = 3*WR + 2;

    logic [5:0] ctrl_ff, nxt_ctrl;
    logic [6:0] pre_ff, nxt_pre;
    logic [4:0] cidx_ff, nxt_cidx;
    logic [WK-1:0] coef_ff [FMAS_COEF_WORDS];
    logic [WK-1:0] nxt_coef [FMAS_COEF_WORDS];
    logic [31:0] rdata_ff, nxt_rdata, cur, merged;
    logic wait_ff, nxt_wait;
    logic [WA-1:0] scan_ff, nxt_scan;
    logic [LANE_COUNT*WA-1:0] a_sel;
    logic [IW-1:0] in_d, in_q;
    logic [PW-1:0] pd, pq;
    logic [WA-1:0] a_q [FMAS_MAX_LANES];
    logic [WB-1:0] b_q [FMAS_MAX_LANES];
    logic [WC-1:0] c_q [FMAS_MAX_LANES];
    logic [WK-1:0] k_q [FMAS_MAX_LANES];
    logic [WR-1:0] prod [FMAS_MAX_LANES];
    logic [WR-1:0] s12, s34, s12_q, s34_q, chain_q, total, base, preload, nxt_res;
    logic sa_eff, sign_a_q, sign_b_q, as1_q, as2_q, ld_q, ld_n_q, p_ld, p_ld_n, load_prod;
    logic acc_en, acc_sub, load_high, run;
    fmas_arep_t arep;

    function automatic logic [WR-1:0] ext(input logic [WR-1:0] v, input int w, input logic sgn);
        return (sgn && v[w-1]) ? (v | ({WR{1'b1}} << w)) : v;
    endfunction

    // products are kept modulo 2**WR; the result width bounds everything downstream
    function automatic logic [WR-1:0] lane_mul(input logic [WA-1:0] a, input logic [WB-1:0] b,
                                               input logic [WC-1:0] c, input logic [WK-1:0] k,
                                               input logic sa, input logic sb);
        logic [WR-1:0] xa, xb, r;
        xa = ext(WR'(a), WA, sa);                             // RULE7
        xb = ext(WR'(b), WB, sb);                             // RULE8
        unique case (PRE_MODE)
            FMAS_PRE_SIMPLE: r = xa * xb;
            FMAS_PRE_INPUT: r = (xa + xb) * ext(WR'(c), WC, sb); // RULE3
            FMAS_PRE_COEF, FMAS_PRE_CONST: r = xa * ext(WR'(k), WK, 1'b1); // RULE20
        endcase
        return r;
    endfunction

    assign acc_en = ctrl_ff[FMAS_ACC_EN_BIT];
    assign acc_sub = ctrl_ff[FMAS_ACC_SUB_BIT];
    assign load_high = ctrl_ff[FMAS_LOAD_HIGH_BIT];
    assign arep = fmas_arep_t'(ctrl_ff[FMAS_AREP_LSB +: 2]);

    // lane zero reads scan-in and each later lane the registered A of the one before
    always_comb
    begin
        a_sel = a_in;                                         // RULE1
        if (A_FROM_SHIFT_CHAIN)
        begin
            a_sel[WA-1:0] = scan_in;                          // RULE15
            for (int i = 1; i < LANE_COUNT; i++)
                a_sel[i*WA +: WA] = a_q[i-1];
        end
    end

    assign in_d = {chain_in, sign_a, sign_b, pair_one_add_sub, pair_two_add_sub, accum_load_n,
                   load_accum, coeff_pick_lane3, coeff_pick_lane2, coeff_pick_lane1,
                   coeff_pick_lane0, c_in, b_in, a_sel};      // RULE2 RULE17

    fmas_stage #(.W(IW), .USED(IN_USED), .CLK_SEL(IN_CLK), .ACLR_SEL(IN_ACLR),
                 .SCLR_SEL(IN_SCLR), .ENA_SEL(IN_ENA)) u_in (
        .clock(clock), .rstn(rstn), .reg_clk_en(reg_clk_en), .aclr(aclr), .sclr(sclr),
        .ena(ena), .d(in_d), .q(in_q));                       // RULE22

    assign ld_q = in_q[FO];
    assign ld_n_q = in_q[FO+1];
    assign as2_q = in_q[FO+2];
    assign as1_q = in_q[FO+3];
    assign sign_b_q = in_q[FO+4];
    assign sign_a_q = in_q[FO+5];

    for (genvar g = 0; g < FMAS_MAX_LANES; g++)
    begin : g_lane
        if (g < LANE_COUNT)
        begin : g_on
            assign a_q[g] = in_q[g*WA +: WA];
            assign b_q[g] = in_q[BO + g*WB +: WB];
            assign c_q[g] = in_q[CO + g*WC +: WC];
        end
        else
        begin : g_off
            assign a_q[g] = '0;
            assign b_q[g] = '0;
            assign c_q[g] = '0;
        end
        assign k_q[g] = coef_ff[{2'(g), in_q[KO + g*CSW +: CSW]}]; // RULE17
    end

    always_comb
    begin
        unique case (arep)
            FMAS_A_UNSIGNED: sa_eff = 1'b0;
            FMAS_A_SIGNED: sa_eff = 1'b1;
            FMAS_A_VARIABLE: sa_eff = sign_a_q;              // RULE7
            default: sa_eff = 1'b0;
        endcase
    end

    always_comb
    begin
        for (int i = 0; i < FMAS_MAX_LANES; i++)
            prod[i] = lane_mul(a_q[i], b_q[i], c_q[i], k_q[i], sa_eff, sign_b_q);
        s12 = as1_q ? prod[0] + prod[1] : prod[0] - prod[1]; // RULE13
        s34 = as2_q ? prod[2] + prod[3] : prod[2] - prod[3]; // RULE14
    end

    assign pd = {ext(WR'(in_q[HO +: WCH]), WCH, 1'b1), s34, s12, ld_n_q, ld_q}; // RULE12

    fmas_stage #(.W(PW), .USED(PIPE_USED), .CLK_SEL(PIPE_CLK), .ACLR_SEL(PIPE_ACLR),
                 .SCLR_SEL(PIPE_SCLR), .ENA_SEL(PIPE_ENA)) u_pipe (
        .clock(clock), .rstn(rstn), .reg_clk_en(reg_clk_en), .aclr(aclr), .sclr(sclr),
        .ena(ena), .d(pd), .q(pq));                           // RULE22

    assign p_ld = pq[0];
    assign p_ld_n = pq[1];
    assign s12_q = pq[2 +: WR];
    assign s34_q = pq[2+WR +: WR];
    assign chain_q = pq[2+2*WR +: WR];

    always_comb
    begin
        preload = (pre_ff < 7'(WR)) ? (WR'(1) << pre_ff) : '0; // RULE19
        total = s12_q + s34_q + chain_q;                      // RULE12 RULE22
        // the held result is the feedback path, so no second copy of the sum is kept
        load_prod = load_high ? p_ld : ~p_ld_n;               // RULE9 RULE10
        base = load_prod ? result : preload;
        nxt_res = total;
        if (acc_en)
            nxt_res = acc_sub ? base - total : base + total;  // RULE21
    end

    // the output bank is always built so that the result comes from a flop
    fmas_stage #(.W(WR), .USED(1'b1), .CLK_SEL(OUT_CLK), .ACLR_SEL(OUT_ACLR),
                 .SCLR_SEL(OUT_SCLR), .ENA_SEL(OUT_ENA)) u_out (
        .clock(clock), .rstn(rstn), .reg_clk_en(reg_clk_en), .aclr(aclr), .sclr(sclr),
        .ena(ena), .d(nxt_res), .q(result));                  // RULE18

    always_comb
    begin
        nxt_scan = '0;
        if (A_FROM_SHIFT_CHAIN && LANE_COUNT > 2)
            nxt_scan = a_q[LANE_COUNT-1];                     // RULE16
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            scan_ff <= '0;
        else
            scan_ff <= nxt_scan;
    end

    assign scan_out = scan_ff;

    // register port: one wait cycle, then a single-cycle answer with waitrequest low
    always_comb
    begin
        unique case (avs_address)
            FMAS_CTRL_OFS: cur = 32'(ctrl_ff);
            FMAS_PRELOAD_OFS: cur = 32'(pre_ff);
            FMAS_CIDX_OFS: cur = 32'(cidx_ff);
            FMAS_CDATA_OFS: cur = 32'(coef_ff[cidx_ff]);
            FMAS_RES_LO_OFS: cur = 32'(64'(result));
            FMAS_RES_HI_OFS: cur = 32'(64'(result) >> 32);
            default: cur = '0;
        endcase
        merged = fmas_be_merge(cur, avs_writedata, avs_byteenable);
        nxt_wait = ~((avs_read | avs_write) & wait_ff);
        nxt_rdata = rdata_ff;
        nxt_ctrl = ctrl_ff;
        nxt_pre = pre_ff;
        nxt_cidx = cidx_ff;
        nxt_coef = coef_ff;
        if (avs_read && wait_ff)
            nxt_rdata = cur;
        if (avs_write && !wait_ff)
        begin
            unique case (avs_address)
                FMAS_CTRL_OFS: nxt_ctrl = merged[5:0] & FMAS_CTRL_MASK;
                FMAS_PRELOAD_OFS: nxt_pre = merged[6:0];
                FMAS_CIDX_OFS: nxt_cidx = merged[4:0];
                FMAS_CDATA_OFS: nxt_coef[cidx_ff] = merged[WK-1:0]; // RULE20
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            wait_ff <= 1'b1;
            rdata_ff <= '0;
            ctrl_ff <= FMAS_CTRL_RST;
            pre_ff <= FMAS_PRELOAD_RST;
            cidx_ff <= '0;
            for (int i = 0; i < FMAS_COEF_WORDS; i++)
                coef_ff[i] <= '0;                             // RULE20
        end
        else
        begin
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
            ctrl_ff <= nxt_ctrl;
            pre_ff <= nxt_pre;
            cidx_ff <= nxt_cidx;
            coef_ff <= nxt_coef;
        end
    end

    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;

    // checks below hold for any clock or enable choice while everything runs
    assign run = &reg_clk_en & &ena & ~|sclr & ~|aclr;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    pair_one_a: // RULE13
    assert property (PIPE_USED && run ##1 run |->
                     s12_q == $past(as1_q ? prod[0] + prod[1] : prod[0] - prod[1]))
        else $error("first pair sum wrong");
    pair_two_a: // RULE14
    assert property (PIPE_USED && LANE_COUNT > 2 && run ##1 run |->
                     s34_q == $past(as2_q ? prod[2] + prod[3] : prod[2] - prod[3]))
        else $error("second pair sum wrong");
    b_unsigned_a: // RULE8
    assert property (PRE_MODE == FMAS_PRE_SIMPLE && WA + WB < WR && !sa_eff && !sign_b_q
                     |-> !prod[0][WR-1])
        else $error("unsigned product came out negative");
    a_signed_a: // RULE7
    assert property (PRE_MODE == FMAS_PRE_SIMPLE && WA + WB < WR && arep == FMAS_A_VARIABLE
                     && sign_a_q && !sign_b_q && a_q[0][WA-1] && b_q[0] != '0 |-> prod[0][WR-1])
        else $error("signed A not honoured");
    preload_val_a: // RULE19
    assert property ((pre_ff < 7'(WR)) ? $onehot(preload) : (preload == '0))
        else $error("preload constant wrong");
    load_low_a: // RULE9
    assert property (run && acc_en && !load_high && p_ld_n ##1 run |->
                     result == $past(acc_sub ? preload - total : preload + total))
        else $error("active-low load did not take preload");
    load_high_a: // RULE10
    assert property (run && acc_en && load_high && p_ld ##1 run |->
                     result == $past(acc_sub ? result - total : result + total))
        else $error("active-high load did not accumulate");
    scan_in_a: // RULE15
    assert property (IN_USED && A_FROM_SHIFT_CHAIN && run ##1 run |->
                     a_q[0] == $past(scan_in))
        else $error("scan-in not taken by lane zero");
    scan_out_a: // RULE16
    assert property ((A_FROM_SHIFT_CHAIN && LANE_COUNT > 2) ?
                     (scan_out == $past(a_q[LANE_COUNT-1])) : (scan_out == '0))
        else $error("scan-out wrong");
    sum_out_a: // RULE22
    assert property (run && !acc_en ##1 run |-> result == $past(s12_q + s34_q + chain_q))
        else $error("result is not the combined sum");

    accum_run_c: cover property (run && acc_en && load_prod ##1 run);
    preload_c: cover property (run && acc_en && !load_prod ##1 run);
    bus_write_c: cover property (avs_write && !avs_waitrequest);
endmodule

// [testbench/fmas_fabric.sv]
// fabric-side model that turns one load choice into the two accumulator load lines
`timescale 1ns/100ps
module fmas_fabric (
    input wire logic load_high,
    input wire logic use_prod,
    output logic accum_load_n,
    output logic load_accum
);
    // only the line of the chosen mode moves; the other rests at its idle level
    assign accum_load_n = load_high ? 1'b1 : ~use_prod;
    assign load_accum = load_high ? use_prod : 1'b0;
endmodule

// [testbench/fmas_top_tb.sv]
// self-checking bench for the four-lane multiply-add datapath
`timescale 1ns/100ps
module fmas_top_tb import fmas_pkg::*;;
    logic clock, rstn, sign_a, sign_b, use_prod, load_high_cfg, accum_load_n, load_accum;
    logic [1:0] aclr, sclr, ena, fmt, rce;
    logic [71:0] a_in, b_in, c_in;
    logic [17:0] scan_in, scan_out, scan_out2;
    logic [89:0] sh;
    logic [43:0] chain_in;
    logic p1, p2, drv_vld, acc_en, acc_sub, avs_read, avs_write, avs_waitrequest;
    logic [2:0] ck0, ck1, ck2, ck3, vsr;
    logic [63:0] result, acc_v, pre_v, last_e;
    logic [63:0] exq[$];
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    int n_mismatch, checked;

    fmas_top #(.IN_ENA(0), .OUT_ACLR(0), .OUT_SCLR(1)) u_fmas_top (.clock(clock), .rstn(rstn),
        .reg_clk_en(rce), .aclr(aclr), .sclr(sclr), .ena(ena), .a_in(a_in), .b_in(b_in),
        .c_in(c_in), .sign_a(sign_a), .sign_b(sign_b), .scan_in(scan_in),
        .accum_load_n(accum_load_n), .load_accum(load_accum), .chain_in(chain_in),
        .pair_one_add_sub(p1), .pair_two_add_sub(p2), .coeff_pick_lane0(ck0),
        .coeff_pick_lane1(ck1), .coeff_pick_lane2(ck2), .coeff_pick_lane3(ck3),
        .result(result), .scan_out(scan_out), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    fmas_fabric u_fmas_fabric (.load_high(load_high_cfg), .use_prod(use_prod),
        .accum_load_n(accum_load_n), .load_accum(load_accum));
    // second copy with lane A fed through the shift chain, so scan-out moves
    fmas_top #(.A_FROM_SHIFT_CHAIN(1'b1)) u_fmas_top_scan (.clock(clock), .rstn(rstn),
        .reg_clk_en(rce), .aclr(aclr), .sclr(sclr), .ena(ena), .a_in(a_in), .b_in(b_in),
        .c_in(c_in), .sign_a(sign_a), .sign_b(sign_b), .scan_in(scan_in),
        .accum_load_n(accum_load_n), .load_accum(load_accum), .chain_in(chain_in),
        .pair_one_add_sub(p1), .pair_two_add_sub(p2), .coeff_pick_lane0(ck0),
        .coeff_pick_lane1(ck1), .coeff_pick_lane2(ck2), .coeff_pick_lane3(ck3),
        .result(), .scan_out(scan_out2), .avs_address(5'h0), .avs_read(1'b0),
        .avs_write(1'b0), .avs_writedata(32'h0), .avs_byteenable(4'h0),
        .avs_readdata(), .avs_waitrequest());

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task test_done;
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one bus cycle held until waitrequest is seen low; reads are compared there
    task bus(input logic wr, input logic [4:0] ad, input logic [31:0] wd,
             input logic [3:0] be, input logic [31:0] ex);
        int n;
        @(posedge clock);
        avs_address <= ad;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= wd;
        avs_byteenable <= be;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0)
        begin
            n_mismatch++;
            test_done();
        end
        if (!wr)
            check("readdata", {32'h0, avs_readdata}, {32'h0, ex});
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // wrap-around arithmetic matches the signed product when both sides are extended
    function automatic logic [63:0] lane_sum(input logic [71:0] a, input logic [71:0] b,
        input logic [43:0] ch, input logic sa, input logic sb, input logic q1, input logic q2);
        logic [63:0] p[4];
        for (int i = 0; i < 4; i++)
            p[i] = {{46{sa & a[i*18+17]}}, a[i*18 +: 18]} * {{46{sb & b[i*18+17]}}, b[i*18 +: 18]};
        return (q1 ? p[0] + p[1] : p[0] - p[1]) + (q2 ? p[2] + p[3] : p[2] - p[3])
            + {{20{ch[43]}}, ch};
    endfunction

    task op;
        logic [95:0] ra, rb, rc, rd;
        logic [63:0] s, base;
        ra = {$urandom(), $urandom(), $urandom()};
        rb = {$urandom(), $urandom(), $urandom()};
        rc = {$urandom(), $urandom(), $urandom()};
        rd = {$urandom(), $urandom(), $urandom()};
        s = lane_sum(ra[71:0], rb[71:0], rd[43:0], fmt == 2'd1 || (fmt == 2'd2 && rd[53]),
            rd[52], rd[51], rd[50]);
        last_e = s;
        if (acc_en)
        begin
            base = rd[66] ? acc_v : pre_v;
            last_e = acc_sub ? base - s : base + s;
            acc_v = last_e;
        end
        @(posedge clock);
        a_in <= ra[71:0];
        b_in <= rb[71:0];
        c_in <= rc[71:0];
        scan_in <= rc[89:72];
        chain_in <= rd[43:0];
        {sign_a, sign_b, p1, p2} <= rd[53:50];
        {ck0, ck1, ck2, ck3} <= rd[65:54];
        use_prod <= acc_en & rd[66];
        drv_vld <= 1'b1;
        exq.push_back(last_e);
    endtask

    task quiet;
        @(posedge clock);
        drv_vld <= 1'b0;
        a_in <= '0;
        b_in <= '0;
        chain_in <= '0;
        use_prod <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    always @(posedge clock)
    begin
        if (vsr[2])
        begin
            check("result", result, exq.pop_front());
            check("scan_out", {46'h0, scan_out}, 64'h0);
        end
        check("scan chain", {46'h0, scan_out2}, {46'h0, sh[89:72]});
        vsr <= {vsr[1:0], drv_vld};
        sh <= {sh[71:0], scan_in};
    end

    initial
    begin
        {rstn, aclr, sclr, sign_a, sign_b, use_prod, load_high_cfg, p1, p2, drv_vld} = '0;
        {a_in, b_in, c_in, scan_in, chain_in, ck0, ck1, ck2, ck3, vsr, sh} = '0;
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
        {fmt, acc_en, acc_sub, acc_v, pre_v, last_e} = '0;
        ena = 2'b11;
        rce = 2'b11;
        n_mismatch = 0;
        checked = 0;
        void'($urandom(42324));
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        bus(1'b0, FMAS_CTRL_OFS, 32'h0, 4'hf, 32'h0);
        bus(1'b0, FMAS_PRELOAD_OFS, 32'h0, 4'hf, 32'h40);
        bus(1'b0, 5'h18, 32'h0, 4'hf, 32'h0);
        bus(1'b1, FMAS_PRELOAD_OFS, 32'h5, 4'he, 32'h0);
        bus(1'b0, FMAS_PRELOAD_OFS, 32'h0, 4'hf, 32'h40);
        bus(1'b1, FMAS_RES_LO_OFS, 32'hffffffff, 4'hf, 32'h0);
        bus(1'b0, FMAS_RES_LO_OFS, 32'h0, 4'hf, 32'h0);
        for (int f = 0; f < 3; f++)
        begin
            fmt = f[1:0];
            bus(1'b1, FMAS_CTRL_OFS, {26'h0, fmt, 4'h0}, 4'hf, 32'h0);
            repeat (20) op();
            quiet();
        end
        fmt = 2'd0;
        for (int m = 0; m < 2; m++)
        begin
            acc_en = 1'b1;
            acc_sub = m[0];
            pre_v = m[0] ? 64'h0 : 64'h1 << 40;
            bus(1'b1, FMAS_PRELOAD_OFS, m[0] ? 32'h40 : 32'h28, 4'hf, 32'h0);
            bus(1'b1, FMAS_CTRL_OFS, m[0] ? 32'h7 : 32'h1, 4'hf, 32'h0);
            load_high_cfg <= m[0];
            quiet();
            bus(1'b0, FMAS_RES_LO_OFS, 32'h0, 4'hf, pre_v[31:0]);
            bus(1'b0, FMAS_RES_HI_OFS, 32'h0, 4'hf, pre_v[63:32]);
            acc_v = pre_v;
            repeat (20) op();
            quiet();
        end
        acc_en = 1'b0;
        bus(1'b1, FMAS_CTRL_OFS, 32'h0, 4'hf, 32'h0);
        op();
        @(posedge clock);
        drv_vld <= 1'b0;
        repeat (5) @(posedge clock);
        ena[0] <= 1'b0;
        a_in <= ~a_in;
        repeat (5) @(posedge clock);
        check("held result", result, last_e);
        ena[0] <= 1'b1;
        aclr[0] <= 1'b1;
        @(posedge clock);
        check("async clear", result, 64'h0);
        aclr[0] <= 1'b0;
        repeat (3) @(posedge clock);
        sclr[1] <= 1'b1;
        @(posedge clock);
        sclr[1] <= 1'b0;
        rce[0] <= 1'b0;
        @(posedge clock);
        check("sync clear", result, 64'h0);
        repeat (3) @(posedge clock);
        check("clock select hold", result, 64'h0);
        test_done();
    end
endmodule
